// File: shared/power_mode_cfg.svh
/*
  Register offsets, field positions and reset values for the power mode
  configuration block. Assumes inclusion by bare name from design files.
*/
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

// ***************************************************************
// register map (byte addresses on the avalon word bus)
// ***************************************************************
`define PMC_CONFIG_ADDR 8'h70
`define PMC_STATUS_ADDR 8'h74
`define PMC_REQUEST_ADDR 8'h78
`define PMC_CONFIG_RESET 16'h0000
`define PMC_CONFIG_MASK 16'hfebf
// byte lane halves of the writable mask; reserved bits 8 and 6 stay zero
`define PMC_MASK_LO 8'hbf
`define PMC_MASK_HI 8'hfe

// ***************************************************************
// field positions of power_management_config
// ***************************************************************
`define PMC_NAP_SUPPRESS_BIT 15
`define PMC_SLEEP_SUPPRESS_BIT 14
`define PMC_SLEEP_KIND_BIT 13
`define PMC_LP_REFRESH_BIT 12
`define PMC_NO_RUN_ACK_BIT 11
`define PMC_QUIESCE_REQUEST_REQUIRED_BIT 10
`define PMC_SUSPEND_QUIESCE_ACK_BIT 9
`define PMC_ENABLE_BIT 7
`define PMC_DOZE_BIT 5
`define PMC_NAP_BIT 4
`define PMC_SLEEP_BIT 3
`define PMC_TEST_CLOCK_OUT_ENABLE_BIT 2
`define PMC_TEST_CLOCK_OUT_SOURCE_BIT 1
`define PMC_WAKE_BIT 0

// ***************************************************************
// cpu type codes and mode request bits
// ***************************************************************
`define PMC_CPU_TYPE_A 2'b00
`define PMC_CPU_TYPE_B 2'b11
`define PMC_REQ_DOZE_BIT 0
`define PMC_REQ_NAP_BIT 1
`define PMC_REQ_SLEEP_BIT 2
`define PMC_REQ_SUSPEND_BIT 3

`endif

// File: shared/power_mode_pkg.sv
/*
  Types for the power mode configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package power_mode_pkg;
  // power states of the device
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DOZE = 3'b001,
    ST_NAP_MSG = 3'b010,
    ST_NAP = 3'b011,
    ST_SLEEP_MSG = 3'b100,
    ST_SLEEP = 3'b101,
    ST_SUSPEND = 3'b110
  } power_state_t;

  // special cycle message kinds
  typedef enum logic [1:0] {
    MSG_SHUTDOWN = 2'b00,
    MSG_HALT = 2'b01
  } pci_message_t;
endpackage : power_mode_pkg

// File: hdl/power_mode_config.sv
/*
  Power mode configuration register and mode sequencer with an Avalon-MM
  slave. Assumes a single 250 MHz clock, synchronous inputs, and a PCI
  message engine that answers each message request with a done pulse.
*/
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_cfg.svh"

module power_mode_config (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // processor side
  input wire logic [1:0] cpu_type_field_i,
  input wire logic quiesce_request_i,
  input wire logic second_cpu_bus_request_i,
  input wire logic wake_event_i,
  output logic quiesce_acknowledge_o,
  // pci message engine
  input wire logic pci_mem_access_i,
  input wire logic msg_done_i,
  output logic msg_req_o,
  output power_mode_pkg::pci_message_t msg_kind_o,
  // memory and clocks
  output logic refresh_enable_o,
  input wire logic internal_clk_i,
  input wire logic system_clock_input_i,
  output logic test_clk_o,
  output logic test_clk_oe_o,
  // state view
  output power_mode_pkg::power_state_t power_state_o
);
  import power_mode_pkg::*;

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [15:0] power_management_config;
  logic [3:0] mode_request;
  power_state_t state;
  power_state_t next_state;
  logic bus_ack;
  logic wr_hit;

  // field shorthands
  wire pm_on = power_management_config[`PMC_ENABLE_BIT];
  wire doze_ok = pm_on && power_management_config[`PMC_DOZE_BIT];
  wire nap_ok = pm_on && power_management_config[`PMC_NAP_BIT];
  wire sleep_ok = pm_on && power_management_config[`PMC_SLEEP_BIT];
  // quiesce gate applies only for cpu type 00
  wire quiesce_request_ok = !(cpu_type_field_i == `PMC_CPU_TYPE_A &&
    power_management_config[`PMC_QUIESCE_REQUEST_REQUIRED_BIT]) ||
    quiesce_request_i;
  wire cpu_wake = power_management_config[`PMC_WAKE_BIT] &&
    second_cpu_bus_request_i;
  wire snoop_wake = cpu_type_field_i == `PMC_CPU_TYPE_B &&
    pci_mem_access_i;

  // ***************************************************************
  // avalon slave: one wait cycle, then acknowledge
  // ***************************************************************
  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read_i || avs_write_i) && !bus_ack;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !bus_ack);
    end
  end

  assign wr_hit = avs_write_i && bus_ack;

  // config register, byte lanes 0 and 1; reserved bits held zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      power_management_config <= `PMC_CONFIG_RESET;
    end else if (wr_hit && avs_address_i == `PMC_CONFIG_ADDR) begin
      if (avs_byteenable_i[0]) begin
        power_management_config[7:0] <= avs_writedata_i[7:0] &
          `PMC_MASK_LO;
      end
      if (avs_byteenable_i[1]) begin
        power_management_config[15:8] <= avs_writedata_i[15:8] &
          `PMC_MASK_HI;
      end
    end
  end

  // software mode requests; hardware clears all four bits on any state change that does not return to run
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_request <= 4'h0;
    end else if (wr_hit && avs_address_i == `PMC_REQUEST_ADDR &&
        avs_byteenable_i[0]) begin
      mode_request <= avs_writedata_i[3:0];
    end else if (state != next_state && next_state != ST_RUN) begin
      mode_request <= 4'h0;
    end
  end

  // read data, registered; unmapped words read zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !bus_ack) begin
      unique case (avs_address_i)
        `PMC_CONFIG_ADDR: avs_readdata_o <= {16'h0000,
          power_management_config};
        `PMC_STATUS_ADDR: avs_readdata_o <= {29'h0000_0000, state};
        `PMC_REQUEST_ADDR: avs_readdata_o <= {28'h000_0000, mode_request};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // mode sequencer
  // ***************************************************************
  // one mode at a time; messages finish before nap or sleep is entered
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (!pm_on) begin
          next_state = ST_RUN;
        end else if (mode_request[`PMC_REQ_SLEEP_BIT] && sleep_ok &&
            quiesce_request_ok) begin
          next_state = power_management_config[`PMC_SLEEP_SUPPRESS_BIT] ?
            ST_SLEEP : ST_SLEEP_MSG;
        end else if (mode_request[`PMC_REQ_NAP_BIT] && nap_ok &&
            quiesce_request_ok) begin
          next_state = power_management_config[`PMC_NAP_SUPPRESS_BIT] ?
            ST_NAP : ST_NAP_MSG;
        end else if (mode_request[`PMC_REQ_DOZE_BIT] && doze_ok) begin
          next_state = ST_DOZE;
        end else if (mode_request[`PMC_REQ_SUSPEND_BIT]) begin
          next_state = ST_SUSPEND;
        end
      end
      ST_NAP_MSG: if (msg_done_i) next_state = ST_NAP;
      ST_SLEEP_MSG: if (msg_done_i) next_state = ST_SLEEP;
      ST_NAP: begin
        if (wake_event_i || cpu_wake || snoop_wake || !pm_on) begin
          next_state = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_event_i || cpu_wake || !pm_on) begin
          next_state = ST_RUN;
        end
      end
      ST_DOZE, ST_SUSPEND: begin
        if (wake_event_i || !pm_on) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      power_state_o <= ST_RUN;
    end else begin
      power_state_o <= next_state;
    end
  end

  // message request held until the engine reports done
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      msg_req_o <= 1'b0;
      msg_kind_o <= MSG_HALT;
    end else begin
      msg_req_o <= (next_state == ST_NAP_MSG ||
        next_state == ST_SLEEP_MSG) && !msg_done_i;
      msg_kind_o <= (next_state == ST_SLEEP_MSG &&
        power_management_config[`PMC_SLEEP_KIND_BIT]) ?
        MSG_SHUTDOWN : MSG_HALT;
    end
  end

  // refresh stops in sleep/suspend unless low-power refresh is on
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      refresh_enable_o <= 1'b1;
    end else begin
      refresh_enable_o <= !(next_state == ST_SLEEP ||
        next_state == ST_SUSPEND) ||
        power_management_config[`PMC_LP_REFRESH_BIT];
    end
  end

  // quiesce acknowledge: suspend entry or snoop run signal after nap
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      quiesce_acknowledge_o <= 1'b0;
    end else if (next_state == ST_SUSPEND) begin
      quiesce_acknowledge_o <=
        power_management_config[`PMC_SUSPEND_QUIESCE_ACK_BIT];
    end else if (state == ST_NAP && next_state == ST_RUN && snoop_wake) begin
      quiesce_acknowledge_o <=
        !power_management_config[`PMC_NO_RUN_ACK_BIT];
    end else if (next_state == ST_RUN) begin
      quiesce_acknowledge_o <= 1'b0;
    end
  end

  // ***************************************************************
  // test clock output
  // ***************************************************************
  // registered, so the pin follows the chosen source one cycle late
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      test_clk_o <= 1'b0;
      test_clk_oe_o <= 1'b0;
    end else begin
      test_clk_o <= power_management_config[`PMC_TEST_CLOCK_OUT_SOURCE_BIT] ?
        system_clock_input_i : internal_clk_i;
      test_clk_oe_o <= power_management_config[`PMC_TEST_CLOCK_OUT_ENABLE_BIT];
    end
  end
endmodule : power_mode_config
`default_nettype wire

// File: test/msg_engine_model.sv
/*
  Stand-in for the pci message engine: one done pulse per message request.
  Assumes the request stays high until the done pulse has been seen.
*/
`timescale 1ns/1ps
`default_nettype none
// ********************
// message engine model
// ********************
module msg_engine_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // request side
  input wire logic msg_req_i,
  input wire logic slow_i,
  output logic msg_done_o
);
  logic [7:0] cnt;
  // count request cycles; saturating, so a long-held request never repeats
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !msg_req_i) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
    msg_done_o <= msg_req_i && !rst_i && cnt == (slow_i ? 8'h09 : 8'h01);
  end
endmodule : msg_engine_model
`default_nettype wire

// File: test/power_mode_config_sva.sv
/*
  Port checker for the power mode block, bound to every instance.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
// ***********
// port checks
// ***********
module power_mode_config_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic msg_req_o,
  input wire logic msg_done_i,
  input wire power_mode_pkg::pci_message_t msg_kind_o,
  input wire power_mode_pkg::power_state_t power_state_o
);
  import power_mode_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence nap_entry;
    power_state_o == ST_NAP_MSG ##1 power_state_o == ST_NAP;
  endsequence
  sequence sleep_entry;
    power_state_o == ST_SLEEP_MSG ##1 power_state_o == ST_SLEEP;
  endsequence
  wait_pulse_a:
  assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a:
  assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without a request");
  answer_bound_a:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[0:2] !avs_waitrequest_o) else $error("request not answered");
  msg_state_a:
  assert property (msg_req_o |-> power_state_o inside {ST_NAP_MSG,
    ST_SLEEP_MSG}) else $error("message request outside broadcast");
  nap_kind_a:
  assert property (power_state_o == ST_NAP_MSG |-> msg_kind_o == MSG_HALT)
    else $error("nap broadcast is not halt");
  nap_done_a:
  assert property (nap_entry |-> $past(msg_done_i))
    else $error("nap entered before broadcast done");
  sleep_done_a:
  assert property (sleep_entry |-> $past(msg_done_i))
    else $error("sleep entered before broadcast done");
  state_legal_a:
  assert property (power_state_o != 3'b111)
    else $error("undefined power state");
endmodule : power_mode_config_sva
bind power_mode_config power_mode_config_sva i_sva (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .msg_req_o(msg_req_o),
  .msg_done_i(msg_done_i), .msg_kind_o(msg_kind_o),
  .power_state_o(power_state_o));
`default_nettype wire

// File: test/power_mode_config_tb.sv
/*
  Self-checking bench for the power mode block over its avalon port.
  Assumes the message engine model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
// *****
// bench
// *****
module power_mode_config_tb;
  import power_mode_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, cpu_req = 0, quiesce_request = 0, pci = 0;
  logic wake = 0, slow = 0, ic = 0, sc = 0, wreq, done, quiesce_acknowledge, mreq, refr;
  logic tclk, toe, sc1, ic1;
  logic [1:0] ctype = 0;
  logic [7:0] adr = 0;
  logic [15:0] lf = 16'hacde;
  logic [15:0] tab [4] = '{16'h0088, 16'h2088, 16'h4088, 16'h1089};
  logic [31:0] wd = 0, q, exp_q [$];
  pci_message_t kind;
  power_state_t st;
  int mismatches = 0, checks_done = 0, reqs = 0, n0;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  initial forever #2 clk = ~clk;
  // random levels on the sampled clock inputs; count message cycles
  always @(posedge clk) begin
    lf <= lfsr(lf);
    ic <= lf[0];
    sc <= lf[5];
    // one cycle history: the test clock pin shows the level seen an edge ago
    sc1 <= sc;
    ic1 <= ic;
    if (mreq) reqs++;
  end
  power_mode_config i_dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(q), .avs_waitrequest_o(wreq),
    .cpu_type_field_i(ctype), .quiesce_request_i(quiesce_request),
    .second_cpu_bus_request_i(cpu_req), .wake_event_i(wake),
    .quiesce_acknowledge_o(quiesce_acknowledge), .pci_mem_access_i(pci),
    .msg_done_i(done), .msg_req_o(mreq), .msg_kind_o(kind),
    .refresh_enable_o(refr), .internal_clk_i(ic),
    .system_clock_input_i(sc), .test_clk_o(tclk), .test_clk_oe_o(toe),
    .power_state_o(st));
  msg_engine_model i_msg (.sys_clk_i(clk), .rst_i(rst), .msg_req_i(mreq),
    .slow_i(slow), .msg_done_o(done));
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // read results are matched against the oldest note as they appear
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) chk("rd", exp_q.pop_front(), q);
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a; wr <= w; rd <= !w; wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      if (++n > 50) begin mismatches++; test_done(); end
      @(posedge clk);
    end
    rd <= 0; wr <= 0;
    @(posedge clk);
  endtask : bus
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask : rdx
  task automatic go(input power_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 40) begin n++; @(posedge clk); end
    chk("state", s, st);
    if (n == 40) test_done();
  endtask : go
  task automatic enter(input logic [15:0] c, input logic [3:0] r,
                       input power_state_t s);
    bus(1, 8'h70, {16'h0000, c});
    bus(1, 8'h78, {28'h000_0000, r});
    go(s);
  endtask : enter
  task automatic leave;
    wake <= 1; @(posedge clk); wake <= 0; go(ST_RUN);
  endtask : leave
  // main sequence: reset, register map, then each power mode in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rdx(8'h70, 0);
    bus(1, 8'h70, 32'hffff_ffff);
    rdx(8'h70, 32'h0000_febf);
    rdx(8'h7c, 0);
    repeat (4) begin
      @(posedge clk);
      chk("test_clk", sc1, tclk);
    end
    chk("test_clk_oe", 1, toe);
    bus(1, 8'h70, 0); repeat (2) @(posedge clk);
    chk("test_clk_oe", 0, toe);
    repeat (4) begin
      @(posedge clk);
      chk("test_clk", ic1, tclk);
    end
    bus(1, 8'h70, 32'h0000_0038); bus(1, 8'h78, 1); repeat (8) @(posedge clk);
    chk("state", ST_RUN, st);
    bus(1, 8'h78, 0);
    enter(16'h00a0, 1, ST_DOZE);
    leave; slow <= 1;
    enter(16'h0090, 2, ST_NAP_MSG);
    chk("msg_kind", MSG_HALT, kind);
    go(ST_NAP);
    leave; slow <= 0; n0 = reqs;
    enter(16'h8090, 2, ST_NAP); chk("msg_cycles", n0, reqs);
    leave;
    foreach (tab[i]) begin
      enter(tab[i], 4, tab[i][14] ? ST_SLEEP : ST_SLEEP_MSG);
      if (!tab[i][14]) begin
        chk("kind", tab[i][13] ? MSG_SHUTDOWN : MSG_HALT, kind);
      end
      go(ST_SLEEP); repeat (2) @(posedge clk);
      chk("refresh", tab[i][12], refr);
      cpu_req <= 1; repeat (4) @(posedge clk);
      chk("state", tab[i][0] ? ST_RUN : ST_SLEEP, st);
      cpu_req <= 0; leave;
    end
    bus(1, 8'h70, 32'h0000_8490); bus(1, 8'h78, 2); repeat (8) @(posedge clk);
    chk("state", ST_RUN, st);
    quiesce_request <= 1; go(ST_NAP);
    leave; quiesce_request <= 0;
    for (int k = 1; k >= 0; k--) begin
      enter(k ? 16'h0280 : 16'h0080, 8, ST_SUSPEND); @(posedge clk);
      chk("quiesce_acknowledge", k, quiesce_acknowledge); leave;
    end
    ctype <= 2'b11;
    for (int j = 1; j >= 0; j--) begin
      enter(j ? 16'h8890 : 16'h8090, 2, ST_NAP); pci <= 1; go(ST_RUN);
      // the snoop acknowledge stands only in the first run cycle
      chk("quiesce_acknowledge", !j, quiesce_acknowledge);
      @(posedge clk);
      pci <= 0;
    end
    test_done();
  end
endmodule : power_mode_config_tb
`default_nettype wire
